// [core/mbd_barrier_decode.v]
/*
 Memory barrier decode and execution control: takes a barrier from the
 pipeline, works out domain and access types, issues one request to the
 memory system when cond_passed is set and holds issue until that request is acknowledged.
 Assumes the memory system raises mem_ack for one cycle per request and
 that the pipeline holds its request until barrier_done.
*/
// What this block does
// - Options 0001/0010/0011 give outer shareable with reads, writes, all.
// - Options 0101/0110/0111 give non-shareable with reads, writes, all.
// - Options 1001/1010/1011 give inner shareable with reads, writes, all.
// - Options 1101/1110/1111 give full system with reads, writes, all.
// - Reserved sync barrier options act as full system, all types.
// - Full-system-all and full barrier code are always supported.
// - Upgrade field 11 at user/kernel non-secure forces full system.
// - Upgrade field 10 raises anything below full system to outer shareable.
// - Upgrade field 01 raises non-shareable to inner shareable, for sync barriers only.
// - Sync barrier option 1100 at hypervisor level is a full barrier.
// - Sync barrier completes only after covered accesses complete.
// - User/kernel sync barrier orders only same virtual machine tag.
// - Hypervisor sync barrier orders only hypervisor level accesses.
// - Ordering barrier uses same mapping and upgrade adjustments, except upgrade field 01.
// - Reserved ordering barrier options act as full system, all types.
// - Full barrier code at user/kernel equals full-system-all sync barrier.
// - Hypervisor full barrier ignores privilege level and machine tag.
`timescale 1ns/1ps
`include "mbd_consts.vh"

module mbd_barrier_decode #(
    parameter TAG_W = 8,
    parameter HAVE_HYP = 1
) (
    input wire mclk,
    input wire srst,
    input wire bar_valid,
    input wire bar_is_sync,
    input wire [3:0] bar_option,
    input wire cond_passed,
    input wire [1:0] current_privilege_level,
    input wire core_secure,
    input wire [1:0] barrier_upgrade_field,
    input wire [TAG_W-1:0] virtual_machine_tag,
    input wire mem_ack,
    output reg bar_ready,
    output reg barrier_done,
    output reg issue_hold,
    output reg mem_req,
    output reg [1:0] mem_kind,
    output reg [1:0] mem_domain,
    output reg [1:0] mem_types,
    output reg mem_match_tag,
    output reg mem_hyp_only,
    output reg [TAG_W-1:0] mem_tag
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0] state_r;
    reg [1:0] dom_base;
    reg [1:0] typ;
    reg [1:0] dom;
    reg lower_ns;
    reg is_hyp;
    reg full_bar;

    always @* begin
        dom_base = `MBD_DOM_SYS;
        typ = `MBD_TYP_ALL;
        is_hyp = (current_privilege_level == `MBD_EL_HYP);
        lower_ns = (HAVE_HYP != 0) && !core_secure && !is_hyp;
        case (bar_option)
            `MBD_OPT_OSH_RD: begin
                dom_base = `MBD_DOM_OSH;
                typ = `MBD_TYP_RD;
            end
            `MBD_OPT_OSH_WR: begin
                dom_base = `MBD_DOM_OSH;
                typ = `MBD_TYP_WR;
            end
            `MBD_OPT_OSH_ALL: begin
                dom_base = `MBD_DOM_OSH;
                typ = `MBD_TYP_ALL;
            end
            `MBD_OPT_NSH_RD: begin
                dom_base = `MBD_DOM_NSH;
                typ = `MBD_TYP_RD;
            end
            `MBD_OPT_NSH_WR: begin
                dom_base = `MBD_DOM_NSH;
                typ = `MBD_TYP_WR;
            end
            `MBD_OPT_NSH_ALL: begin
                dom_base = `MBD_DOM_NSH;
                typ = `MBD_TYP_ALL;
            end
            `MBD_OPT_ISH_RD: begin
                dom_base = `MBD_DOM_ISH;
                typ = `MBD_TYP_RD;
            end
            `MBD_OPT_ISH_WR: begin
                dom_base = `MBD_DOM_ISH;
                typ = `MBD_TYP_WR;
            end
            `MBD_OPT_ISH_ALL: begin
                dom_base = `MBD_DOM_ISH;
                typ = `MBD_TYP_ALL;
            end
            // full system reads, writes or all
            `MBD_OPT_SYS_RD: begin
                dom_base = `MBD_DOM_SYS;
                typ = `MBD_TYP_RD;
            end
            `MBD_OPT_SYS_WR: begin
                dom_base = `MBD_DOM_SYS;
                typ = `MBD_TYP_WR;
            end
            `MBD_OPT_SYS_ALL: begin
                dom_base = `MBD_DOM_SYS;
                typ = `MBD_TYP_ALL;
            end
            `MBD_OPT_FULL_CODE: begin
                dom_base = `MBD_DOM_SYS;
                typ = `MBD_TYP_ALL;
            end
            default: begin
                dom_base = `MBD_DOM_SYS;
                typ = `MBD_TYP_ALL;
            end
        endcase
        dom = dom_base;
        if (lower_ns) begin
            if (barrier_upgrade_field == `MBD_BSU_SYS) begin
                dom = `MBD_DOM_SYS;
            end else if (barrier_upgrade_field == `MBD_BSU_OSH && dom_base != `MBD_DOM_SYS) begin
                dom = `MBD_DOM_OSH;
            end else if (barrier_upgrade_field == `MBD_BSU_ISH && bar_is_sync && dom_base == `MBD_DOM_NSH) begin
                dom = `MBD_DOM_ISH;
            end
        end
        full_bar = bar_is_sync && (bar_option == `MBD_OPT_FULL_CODE) && is_hyp;
    end

    always @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            bar_ready <= 1'b0;
            barrier_done <= 1'b0;
            issue_hold <= 1'b0;
            mem_req <= 1'b0;
            mem_kind <= `MBD_KIND_ORDER;
            mem_domain <= `MBD_DOM_SYS;
            mem_types <= `MBD_TYP_ALL;
            mem_match_tag <= 1'b0;
            mem_hyp_only <= 1'b0;
            mem_tag <= {TAG_W{1'b0}};
        end else begin
            bar_ready <= 1'b0;
            barrier_done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (bar_valid) begin
                        bar_ready <= 1'b1;
                        if (!cond_passed) begin
                            barrier_done <= 1'b1;
                            state_r <= ST_DONE;
                        end else begin
                            mem_req <= 1'b1;
                            issue_hold <= 1'b1;
                            mem_domain <= dom;
                            mem_types <= typ;
                            mem_tag <= virtual_machine_tag;
                            if (full_bar) begin
                                mem_kind <= `MBD_KIND_FULL;
                                mem_domain <= `MBD_DOM_SYS;
                                mem_types <= `MBD_TYP_ALL;
                                mem_match_tag <= 1'b0;
                                mem_hyp_only <= 1'b0;
                            end else begin
                                // 1100 below hypervisor acts as full-system-all
                                mem_kind <= bar_is_sync ? `MBD_KIND_SYNC : `MBD_KIND_ORDER;
                                mem_match_tag <= !is_hyp;
                                mem_hyp_only <= is_hyp;
                            end
                            state_r <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        issue_hold <= 1'b0;
                        barrier_done <= 1'b1;
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // One idle cycle so the pipeline can drop bar_valid
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// [core/mbd_consts.vh]
/*
 Constants for the memory barrier decoder: option codes, domain and
 access-type encodings, privilege level codes and upgrade field values.
 Assumes inclusion by bare name from the design file.
*/
`ifndef MBD_CONSTS_VH
`define MBD_CONSTS_VH

// Option codes
`define MBD_OPT_OSH_RD 4'h1
`define MBD_OPT_OSH_WR 4'h2
`define MBD_OPT_OSH_ALL 4'h3
`define MBD_OPT_NSH_RD 4'h5
`define MBD_OPT_NSH_WR 4'h6
`define MBD_OPT_NSH_ALL 4'h7
`define MBD_OPT_ISH_RD 4'h9
`define MBD_OPT_ISH_WR 4'ha
`define MBD_OPT_ISH_ALL 4'hb
`define MBD_OPT_FULL_CODE 4'hc
`define MBD_OPT_SYS_RD 4'hd
`define MBD_OPT_SYS_WR 4'he
`define MBD_OPT_SYS_ALL 4'hf

// Domain encodings
`define MBD_DOM_NSH 2'h0
`define MBD_DOM_ISH 2'h1
`define MBD_DOM_OSH 2'h2
`define MBD_DOM_SYS 2'h3

// Access-type encodings
`define MBD_TYP_RD 2'h1
`define MBD_TYP_WR 2'h2
`define MBD_TYP_ALL 2'h3

// Privilege levels
`define MBD_EL_USER 2'h0
`define MBD_EL_KERNEL 2'h1
`define MBD_EL_HYP 2'h2

// Upgrade field values
`define MBD_BSU_ISH 2'h1
`define MBD_BSU_OSH 2'h2
`define MBD_BSU_SYS 2'h3

// Request kinds
`define MBD_KIND_ORDER 2'h0
`define MBD_KIND_SYNC 2'h1
`define MBD_KIND_FULL 2'h2

`endif

// [sim/mbd_barrier_decode_checker.sv]
/* Assertions on the barrier decoder ports.
   Bound onto mbd_barrier_decode; sees its ports only. */
`timescale 1ns/1ps
module mbd_chk (
    input wire mclk,
    input wire srst,
    input wire bar_is_sync,
    input wire [3:0] bar_option,
    input wire [1:0] current_privilege_level,
    input wire mem_ack,
    input wire bar_ready,
    input wire barrier_done,
    input wire issue_hold,
    input wire mem_req,
    input wire [1:0] mem_kind,
    input wire [1:0] mem_domain,
    input wire [1:0] mem_types,
    input wire mem_match_tag,
    input wire mem_hyp_only
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_ready_pulse: assert property (bar_ready |=> !bar_ready)
        else $error("ready too long");
    a_skip_request: assert property (bar_ready && !mem_req |-> barrier_done)
        else $error("failed barrier not done");
    a_hold_wait: assert property (mem_req && !mem_ack |=>
        mem_req && issue_hold && $stable({mem_domain, mem_types}))
        else $error("request dropped early");
    a_ack_done: assert property (mem_req && mem_ack |=> !mem_req && !issue_hold && barrier_done)
        else $error("no done after ack");
    a_dead_cycle: assert property (barrier_done |=> !barrier_done && !bar_ready && !mem_req)
        else $error("no idle cycle");
    a_full_hyp: assert property ($rose(mem_req) && $past(bar_is_sync && bar_option == 4'hc &&
        current_privilege_level == 2'h2) |-> {mem_kind, mem_domain, mem_types, mem_match_tag, mem_hyp_only} == 8'hbc)
        else $error("bad full barrier");
    a_hyp_scope: assert property ($rose(mem_req) && mem_kind != 2'h2 |->
        mem_hyp_only == ($past(current_privilege_level) == 2'h2) && mem_match_tag != mem_hyp_only)
        else $error("bad scope flags");
    a_sys_all: assert property ($rose(mem_req) && $past(bar_option) == 4'hf |->
        mem_domain == 2'h3 && mem_types == 2'h3)
        else $error("bad full system all");
endmodule
bind mbd_barrier_decode mbd_chk i_chk (.mclk(mclk), .srst(srst), .bar_is_sync(bar_is_sync), .bar_option(bar_option),
    .current_privilege_level(current_privilege_level), .mem_ack(mem_ack), .bar_ready(bar_ready),
    .barrier_done(barrier_done),
    .issue_hold(issue_hold), .mem_req(mem_req), .mem_kind(mem_kind), .mem_domain(mem_domain), .mem_types(mem_types),
    .mem_match_tag(mem_match_tag), .mem_hyp_only(mem_hyp_only));

// [sim/mbd_mem.sv]
/* Memory system model: acks each request once, 1 to 6 cycles after mem_req rises.
   Assumes mem_req holds until the ack is seen. */
`timescale 1ns/1ps
module mbd_mem (
    input wire mclk,
    input wire srst,
    input wire mem_req,
    output logic mem_ack
);
    logic [2:0] wait_r;
    always @(posedge mclk) begin
        if (srst || !mem_req || mem_ack) begin
            mem_ack <= 1'b0;
            wait_r <= 3'($urandom_range(5, 0));
        end else if (wait_r == 3'h0) begin
            mem_ack <= 1'b1;
        end else begin
            wait_r <= wait_r - 3'h1;
        end
    end
endmodule

// [sim/tb.sv]
/* Self-checking bench for the barrier decoder.
   Assumes the memory model acks every request. */
`timescale 1ns/1ps
module tb;
    logic mclk, srst, bar_valid, bar_is_sync, cond_passed, core_secure, mem_ack, bar_ready, barrier_done, issue_hold;
    logic mem_req, mem_match_tag, mem_hyp_only;
    logic [3:0] bar_option;
    logic [1:0] current_privilege_level, barrier_upgrade_field, mem_kind, mem_domain, mem_types;
    logic [7:0] virtual_machine_tag, mem_tag;
    int miscompares = 0;
    int compares = 0;
    mbd_barrier_decode i_dut (.mclk(mclk), .srst(srst), .bar_valid(bar_valid), .bar_is_sync(bar_is_sync),
        .bar_option(bar_option), .cond_passed(cond_passed), .current_privilege_level(current_privilege_level),
        .core_secure(core_secure), .barrier_upgrade_field(barrier_upgrade_field),
        .virtual_machine_tag(virtual_machine_tag), .mem_ack(mem_ack), .bar_ready(bar_ready),
        .barrier_done(barrier_done), .issue_hold(issue_hold), .mem_req(mem_req),
        .mem_kind(mem_kind), .mem_domain(mem_domain), .mem_types(mem_types), .mem_match_tag(mem_match_tag),
        .mem_hyp_only(mem_hyp_only), .mem_tag(mem_tag));
    mbd_mem i_mem (.mclk(mclk), .srst(srst), .mem_req(mem_req), .mem_ack(mem_ack));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Returns kind, domain, types, tag match, hypervisor only
    function automatic logic [7:0] exp_f(input logic s, input logic [3:0] o, input logic [1:0] el, input logic sec,
        input logic [1:0] b);
        logic [1:0] d, t;
        logic hyp, full;
        hyp = (el == 2'h2);
        full = s && hyp && o == 4'hc;
        t = (o[1:0] == 2'h0) ? 2'h3 : o[1:0];
        // Option group to outer, non, inner, full system
        d = (o[1:0] == 2'h0) ? 2'h3 : 2'(8'hd2 >> {o[3:2], 1'b0});
        if (!hyp && !sec) begin
            if (b == 2'h3)
                d = 2'h3;
            else if (b == 2'h2 && d != 2'h3)
                d = 2'h2;
            else if (b == 2'h1 && s && d == 2'h0)
                d = 2'h1;
        end
        return {full ? 2'h2 : {1'b0, s}, d, t, !hyp, hyp && !full};
    endfunction
    task automatic run(input logic s, input logic [3:0] o, input logic [1:0] el, input logic sec, input logic [1:0] b,
        input logic c);
        logic [7:0] e;
        int n;
        e = exp_f(s, o, el, sec, b);
        {bar_is_sync, bar_option, current_privilege_level} = {s, o, el};
        {core_secure, barrier_upgrade_field, cond_passed} = {sec, b, c};
        virtual_machine_tag = 8'($urandom);
        bar_valid = 1'b1;
        @(negedge mclk);
        chk("bar_ready", bar_ready, 1'b1);
        if (c) begin
            chk("request flags", {mem_req, issue_hold, mem_match_tag, mem_hyp_only}, {2'b11, e[1:0]});
            chk("request kind", {mem_kind, mem_domain, mem_types}, e[7:2]);
            if (el != 2'h2)
                chk("mem_tag", mem_tag, virtual_machine_tag);
        end
        for (n = 0; n < 20 && !barrier_done; n++)
            @(negedge mclk);
        chk("done", {barrier_done, mem_req, issue_hold}, 3'b100);
        if (n == 20)
            miscompares++;
        bar_valid = 1'b0;
        @(negedge mclk);
    endtask
    initial begin
        void'($urandom(32'hf5df9d29));
        srst = 1'b1;
        {bar_valid, bar_is_sync, bar_option, cond_passed, current_privilege_level, core_secure} = '0;
        {barrier_upgrade_field, virtual_machine_tag} = '0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        for (int i = 0; i < 32; i++)
            run(i[4], i[3:0], 2'h0, 1'b0, 2'h0, 1'b1);
        for (int i = 0; i < 8; i++)
            run(i[0], 4'h5, 2'h1, 1'b0, i[2:1], 1'b1);
        run(1'b1, 4'hc, 2'h2, 1'b0, 2'h3, 1'b1);
        run(1'b1, 4'h5, 2'h1, 1'b1, 2'h3, 1'b1);
        run(1'b1, 4'hc, 2'h2, 1'b0, 2'h0, 1'b0);
        // Reset while a request is outstanding
        {bar_is_sync, bar_option, cond_passed, bar_valid} = {1'b1, 4'h3, 1'b1, 1'b1};
        @(negedge mclk);
        srst = 1'b1;
        bar_valid = 1'b0;
        repeat (2) @(negedge mclk);
        chk("reset pulses", {bar_ready, barrier_done, issue_hold, mem_req}, 4'h0);
        chk("reset request", {mem_kind, mem_domain, mem_types, mem_match_tag, mem_hyp_only}, 8'h3c);
        chk("reset tag", mem_tag, 8'h00);
        srst = 1'b0;
        repeat (200)
            run(1'($urandom), 4'($urandom), 2'($urandom_range(2, 0)), 1'($urandom), 2'($urandom), 1'($urandom));
        stop_test();
    end
endmodule
